// [hdl/scc_speed_select.sv]
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module scc_speed_select #(
    parameter int NUM_INPUTS  = scc_pkg::NUM_DI,
    parameter int SPEED_LIMIT = 50000
) (
    input  wire logic                       clock_in,
    input  wire logic                       rst_b_in,
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [scc_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [scc_pkg::DATA_W-1:0] pwdata_in,
    output logic      [scc_pkg::DATA_W-1:0] prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,
    input  wire logic [NUM_INPUTS-1:0]      din_in,
    input  wire logic signed [scc_pkg::SPD_W-1:0] analog_speed_in,
    input  wire logic [scc_pkg::MODE_W-1:0] mode_nv_in,
    input  wire logic                       alarm_set_in,
    output logic signed [scc_pkg::SPD_W-1:0] speed_cmd_out,
    output logic      [1:0]                 speed_index_out,
    output logic                            drive_on_out,
    output logic                            ccw_out,
    output logic                            torque_limit_out,
    output logic                            alarm_latched_out,
    output logic                            emergency_out,
    output logic                            fwd_limit_out,
    output logic                            rev_limit_out,
    output logic                            irq_out
);
    localparam int SW = scc_pkg::SPD_W;

    // Map holds one to nine code words; speed must fit the signed field
    if (NUM_INPUTS < 1 || NUM_INPUTS > scc_pkg::NUM_DI)
        $error("NUM_INPUTS out of range");
    if (SPEED_LIMIT < 1 || SPEED_LIMIT >= (1 << (SW - 1)))
        $error("SPEED_LIMIT does not fit the speed field");

    logic [NUM_INPUTS-1:0]       sync1_reg;
    logic [NUM_INPUTS-1:0]       sync2_reg;
    logic [NUM_INPUTS-1:0]       act;
    logic [scc_pkg::CODE_W-1:0]  code_reg [NUM_INPUTS];
    logic signed [SW-1:0]        spd_reg [3];
    scc_pkg::scc_func_t          func_next;
    scc_pkg::scc_func_t          func_reg;
    scc_pkg::scc_src_t           src;
    logic [scc_pkg::MODE_W-1:0]  mode_reg;
    logic                        started_reg;
    logic                        alarm_reg;
    logic                        drive_next;
    logic                        drive_reg;
    logic signed [SW-1:0]        sel_speed;
    logic signed [SW-1:0]        cmd_next;
    logic signed [SW-1:0]        cmd_reg;
    logic [1:0]                  idx_reg;
    logic                        ccw_reg;
    logic [scc_pkg::INT_W-1:0]   int_stat_reg;
    logic [scc_pkg::INT_W-1:0]   int_mask_reg;
    logic [scc_pkg::INT_W-1:0]   ev;
    logic                        irq_reg;
    logic [scc_pkg::DATA_W-1:0]  rdata;
    logic                        hit;
    logic                        setup;
    logic                        wr;
    logic [scc_pkg::DATA_W-1:0]  prdata_reg;
    logic                        pready_reg;
    logic                        pslverr_reg;
    logic                        range_bad;
    logic [1:0]                  spd_sel;
    logic                        spd_hit;
    logic                        speed_mode;

    // Two flops per pin; only the second stage feeds decode
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
            always_ff @(posedge clock_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= din_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
            // Normally-open acts on high, anything else on low
            assign act[gi] =
                (code_reg[gi][scc_pkg::POL_MSB:scc_pkg::POL_LSB]
                 == scc_pkg::POL_NO) ? sync2_reg[gi]
                                     : !sync2_reg[gi];
        end
    endgenerate

    // Function decode; several inputs on one function are ORed
    always_comb begin
        func_next = '0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (code_reg[i] != scc_pkg::CODE_OFF && act[i]) begin
                case (code_reg[i][scc_pkg::FN_MSB:scc_pkg::FN_LSB])
                    scc_pkg::FN_ENABLE:  func_next.enable    = 1'b1;
                    scc_pkg::FN_ALM_CLR: func_next.alarm_clr = 1'b1;
                    scc_pkg::FN_TORQUE:  func_next.torque    = 1'b1;
                    scc_pkg::FN_SEL_LO:  func_next.sel_lo    = 1'b1;
                    scc_pkg::FN_SEL_HI:  func_next.sel_hi    = 1'b1;
                    scc_pkg::FN_EMG:     func_next.emg       = 1'b1;
                    scc_pkg::FN_REV_LIM: func_next.rev_lim   = 1'b1;
                    scc_pkg::FN_FWD_LIM: func_next.fwd_lim   = 1'b1;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in)
            func_reg <= '0;
        else
            func_reg <= func_next;
    end

    // Mode is sampled once after release; later changes need reset
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_reg    <= '0;
            started_reg <= 1'b0;
        end else if (!started_reg) begin
            mode_reg    <= mode_nv_in;
            started_reg <= 1'b1;
        end
    end
    assign speed_mode = started_reg && (mode_reg == scc_pkg::MODE_SPEED);

    // Latched alarm; a new alarm beats a clear in the same cycle
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in)
            alarm_reg <= 1'b0;
        else if (alarm_set_in)
            alarm_reg <= 1'b1;
        else if (func_reg.alarm_clr)
            alarm_reg <= 1'b0;
    end

    // Source pick from the select pair
    assign src = scc_pkg::scc_src_t'({func_reg.sel_hi,
                                      func_reg.sel_lo});
    always_comb begin
        case (src)
            scc_pkg::SRC_ANALOG:       sel_speed = analog_speed_in;
            scc_pkg::SRC_STORED_ONE:   sel_speed = spd_reg[0];
            scc_pkg::SRC_STORED_TWO:   sel_speed = spd_reg[1];
            scc_pkg::SRC_STORED_THREE: sel_speed = spd_reg[2];
            default:                   sel_speed = '0;
        endcase
    end

    // Drive runs on the enable level in speed mode unless halted or in alarm
    assign drive_next = func_reg.enable && speed_mode
                        && !func_reg.emg && !alarm_reg;

    // A limit only blocks travel toward it; counts stay 0.1 r/min
    always_comb begin
        cmd_next = sel_speed;
        if (!drive_next)
            cmd_next = '0;
        else if (func_reg.fwd_lim && sel_speed > 0)
            cmd_next = '0;
        else if (func_reg.rev_lim && sel_speed < 0)
            cmd_next = '0;
    end

    // Command and index move together on one edge, every cycle
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmd_reg   <= '0;
            idx_reg   <= '0;
            ccw_reg   <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            cmd_reg   <= cmd_next;
            idx_reg   <= src;
            ccw_reg   <= (cmd_next < 0);
            drive_reg <= drive_next;
        end
    end

    // Bus phases; answer always comes in the first access cycle
    assign setup = psel_in && !penable_in;
    assign wr    = psel_in && penable_in && pready_reg && pwrite_in;
    assign spd_sel = 2'((paddr_in - scc_pkg::ADDR_SPD_BASE) >> 2);
    assign spd_hit = paddr_in >= scc_pkg::ADDR_SPD_BASE
                     && paddr_in < scc_pkg::ADDR_FC_BASE;
    assign range_bad = ($signed(pwdata_in) > SPEED_LIMIT)
                       || ($signed(pwdata_in) < -SPEED_LIMIT);

    // Read mux and address decode
    always_comb begin
        rdata = '0;
        hit   = 1'b1;
        if (spd_hit) begin
            rdata = 32'($signed(spd_reg[spd_sel]));
        end else if (paddr_in == scc_pkg::ADDR_STATUS) begin
            rdata[scc_pkg::ST_IDX_LSB +: 2] = idx_reg;
            rdata[scc_pkg::ST_DRIVE]  = drive_reg;
            rdata[scc_pkg::ST_ALARM]  = alarm_reg;
            rdata[scc_pkg::ST_EMG]    = func_reg.emg;
            rdata[scc_pkg::ST_REV]    = func_reg.rev_lim;
            rdata[scc_pkg::ST_FWD]    = func_reg.fwd_lim;
            rdata[scc_pkg::ST_TORQUE] = func_reg.torque;
            rdata[scc_pkg::ST_MODE_LSB +: scc_pkg::MODE_W] = mode_reg;
        end else if (paddr_in == scc_pkg::ADDR_INT_STAT) begin
            rdata[scc_pkg::INT_W-1:0] = int_stat_reg;
        end else if (paddr_in == scc_pkg::ADDR_INT_MASK) begin
            rdata[scc_pkg::INT_W-1:0] = int_mask_reg;
        end else if (paddr_in == scc_pkg::ADDR_CMD) begin
            rdata = 32'($signed(cmd_reg));
        end else begin
            hit = 1'b0;
            for (int i = 0; i < NUM_INPUTS; i++) begin
                if (paddr_in == scc_pkg::ADDR_FC_BASE
                    + 8'(i * scc_pkg::ADDR_STEP)) begin
                    rdata[scc_pkg::CODE_W-1:0] = code_reg[i];
                    hit = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !hit;
            prdata_reg  <= setup ? rdata : '0;
        end
    end

    // Stored speeds; out-of-range writes are dropped and flagged
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int k = 0; k < 3; k++)
                spd_reg[k] <= scc_pkg::SPD_RESET;
        end else if (wr && spd_hit && !range_bad) begin
            spd_reg[spd_sel] <= pwdata_in[SW-1:0];
        end
    end

    // Function codes; defaults keep the limits and halt armed
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int k = 0; k < NUM_INPUTS; k++)
                code_reg[k] <= scc_pkg::DI_DEFAULT[k];
        end else if (wr) begin
            for (int k = 0; k < NUM_INPUTS; k++)
                if (paddr_in == scc_pkg::ADDR_FC_BASE
                    + 8'(k * scc_pkg::ADDR_STEP))
                    code_reg[k] <= pwdata_in[scc_pkg::CODE_W-1:0];
        end
    end

    // Events for the sticky status
    always_comb begin
        ev = '0;
        ev[scc_pkg::INT_SEL]     = drive_next && (src != idx_reg);
        ev[scc_pkg::INT_ALM_SET] = alarm_set_in && !alarm_reg;
        ev[scc_pkg::INT_ALM_CLR] = alarm_reg && func_reg.alarm_clr
                                   && !alarm_set_in;
        ev[scc_pkg::INT_RANGE]   = wr && spd_hit && range_bad;
        ev[scc_pkg::INT_DRIVE]   = drive_next != drive_reg;
    end

    // Write one clears; a new event in that cycle survives
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            int_stat_reg <= '0;
            int_mask_reg <= '0;
        end else begin
            if (wr && paddr_in == scc_pkg::ADDR_INT_STAT)
                int_stat_reg <= (int_stat_reg
                    & ~pwdata_in[scc_pkg::INT_W-1:0]) | ev;
            else
                int_stat_reg <= int_stat_reg | ev;
            if (wr && paddr_in == scc_pkg::ADDR_INT_MASK)
                int_mask_reg <= pwdata_in[scc_pkg::INT_W-1:0];
        end
    end

    // One cycle behind status, to keep the pin on a flop
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(int_stat_reg & int_mask_reg);
    end

    assign prdata_out        = prdata_reg;
    assign pready_out        = pready_reg;
    assign pslverr_out       = pslverr_reg;
    assign speed_cmd_out     = cmd_reg;
    assign speed_index_out   = idx_reg;
    assign drive_on_out      = drive_reg;
    assign ccw_out           = ccw_reg;
    assign torque_limit_out  = func_reg.torque;
    assign alarm_latched_out = alarm_reg;
    assign emergency_out     = func_reg.emg;
    assign fwd_limit_out     = func_reg.fwd_lim;
    assign rev_limit_out     = func_reg.rev_lim;
    assign irq_out           = irq_reg;

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    logic go;
    logic all_off;
    assign go = drive_next && !func_reg.fwd_lim && !func_reg.rev_lim;
    always_comb begin
        all_off = 1'b1;
        for (int i = 0; i < NUM_INPUTS; i++)
            if (code_reg[i] != scc_pkg::CODE_OFF)
                all_off = 1'b0;
    end

    // No input carries the low select function any more
    logic lo_unmapped;
    always_comb begin
        lo_unmapped = 1'b1;
        for (int i = 0; i < NUM_INPUTS; i++)
            if (code_reg[i][scc_pkg::FN_MSB:scc_pkg::FN_LSB]
                == scc_pkg::FN_SEL_LO)
                lo_unmapped = 1'b0;
    end

    chk_zero_code_off: assert property (
        all_off ##1 all_off |=> func_reg == '0)
        else $error("disabled input changed a function");
    chk_zero_code_sel: assert property (
        lo_unmapped ##1 lo_unmapped |=> !func_reg.sel_lo)
        else $error("disabled select input still acts");
    chk_analog_src: assert property (
        go && src == scc_pkg::SRC_ANALOG
        |=> speed_cmd_out == $past(analog_speed_in))
        else $error("analog source not followed");
    chk_stored_one: assert property (
        go && !func_reg.sel_hi && func_reg.sel_lo
        |=> speed_cmd_out == $past(spd_reg[0]) && speed_index_out == 2'h1)
        else $error("stored speed one not used");
    chk_stored_two: assert property (
        go && func_reg.sel_hi && !func_reg.sel_lo
        |=> speed_cmd_out == $past(spd_reg[1]) && speed_index_out == 2'h2)
        else $error("stored speed two not used");
    chk_stored_three: assert property (
        go && func_reg.sel_hi && func_reg.sel_lo
        |=> speed_cmd_out == $past(spd_reg[2]) && speed_index_out == 2'h3)
        else $error("stored speed three not used");
    chk_speed_range: assert property (
        spd_reg[0] <= SPEED_LIMIT && spd_reg[0] >= -SPEED_LIMIT)
        else $error("stored speed out of range");
    chk_dir_sign: assert property (
        ccw_out == (speed_cmd_out < 0))
        else $error("direction disagrees with command sign");
    chk_drive_off_zero: assert property (
        !drive_on_out |-> speed_cmd_out == '0)
        else $error("command while drive off");
    chk_alarm_clear: assert property (
        alarm_latched_out && func_reg.alarm_clr && !alarm_set_in
        |=> !alarm_latched_out ##1 (alarm_latched_out == $past(alarm_set_in)))
        else $error("alarm clear not honoured");
    chk_mode_gate: assert property (
        started_reg && mode_reg != scc_pkg::MODE_SPEED
        |=> !drive_on_out [*2])
        else $error("drive on outside speed mode");
    chk_bus_answer: assert property (
        setup |=> pready_out && pslverr_out == !$past(hit))
        else $error("bus answer missing");

    cov_stored_three: cover property (
        drive_on_out && speed_index_out == 2'h3);
    cov_alarm_cycle: cover property (
        alarm_latched_out ##[1:20] !alarm_latched_out);
    cov_irq: cover property ($rose(irq_out));
endmodule : scc_speed_select

// [hdl/scc_pkg.sv]
package scc_pkg;
    // Sizes
    localparam int NUM_DI = 9;
    localparam int CODE_W = 16;
    localparam int SPD_W  = 17;
    localparam int MODE_W = 4;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int INT_W  = 5;

    // Control mode value for speed control
    localparam logic [MODE_W-1:0] MODE_SPEED = 4'h2;

    // Function code layout: polarity byte over function byte
    localparam int FN_LSB  = 0;
    localparam int FN_MSB  = 7;
    localparam int POL_LSB = 8;
    localparam int POL_MSB = 15;
    localparam logic [7:0] POL_NC = 8'h00;
    localparam logic [7:0] POL_NO = 8'h01;
    localparam logic [7:0] FN_ENABLE  = 8'h01;
    localparam logic [7:0] FN_ALM_CLR = 8'h02;
    localparam logic [7:0] FN_TORQUE  = 8'h09;
    localparam logic [7:0] FN_SEL_LO  = 8'h14;
    localparam logic [7:0] FN_SEL_HI  = 8'h15;
    localparam logic [7:0] FN_EMG     = 8'h21;
    localparam logic [7:0] FN_REV_LIM = 8'h22;
    localparam logic [7:0] FN_FWD_LIM = 8'h23;
    localparam logic [CODE_W-1:0] CODE_OFF = 16'h0000;

    // Power-up function codes, input 1 first
    localparam logic [CODE_W-1:0] DI_DEFAULT [NUM_DI] = '{
        16'h0101, 16'h0109, 16'h0114, 16'h0115, 16'h0102,
        16'h0022, 16'h0023, 16'h0021, 16'h0000};
    localparam logic [SPD_W-1:0] SPD_RESET = 17'h00000;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_SPD_BASE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_FC_BASE  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h34;
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h3c;
    localparam logic [ADDR_W-1:0] ADDR_CMD      = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_STEP     = 8'h04;

    // Interrupt bits
    localparam int INT_SEL     = 0;
    localparam int INT_ALM_SET = 1;
    localparam int INT_ALM_CLR = 2;
    localparam int INT_RANGE   = 3;
    localparam int INT_DRIVE   = 4;

    // Status bits
    localparam int ST_IDX_LSB  = 0;
    localparam int ST_DRIVE    = 2;
    localparam int ST_ALARM    = 3;
    localparam int ST_EMG      = 4;
    localparam int ST_REV      = 5;
    localparam int ST_FWD      = 6;
    localparam int ST_TORQUE   = 7;
    localparam int ST_MODE_LSB = 8;

    // Speed command sources
    typedef enum logic [1:0] {
        SRC_ANALOG       = 2'b00,
        SRC_STORED_ONE   = 2'b01,
        SRC_STORED_TWO   = 2'b10,
        SRC_STORED_THREE = 2'b11
    } scc_src_t;

    // Decoded input functions
    typedef struct packed {
        logic enable;
        logic alarm_clr;
        logic torque;
        logic sel_lo;
        logic sel_hi;
        logic emg;
        logic rev_lim;
        logic fwd_lim;
    } scc_func_t;
endpackage : scc_pkg

// [testbench/scc_ctrl_model.sv]
`timescale 1ns/1ps
// Motion controller side: turns requests into pin levels on the inputs
module scc_ctrl_model (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic       enable_req_in,
    input  wire logic       alarm_clr_req_in,
    input  wire logic [1:0] sel_req_in,
    input  wire logic       safe_in,
    output logic      [8:0] din_out
);
    // Pins move only after a clock edge, like a real output card
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            din_out <= 9'h000;
        end else begin
            din_out[0]   <= enable_req_in;
            din_out[1]   <= 1'b0;
            din_out[3:2] <= sel_req_in;
            din_out[4]   <= alarm_clr_req_in;
            // Closed contacts mean no fault on inputs six to eight
            din_out[7:5] <= {3{safe_in}};
            din_out[8]   <= 1'b0;
        end
    end
endmodule : scc_ctrl_model

// [testbench/speed_command_input_select_tb.sv]
`timescale 1ns/1ps
module speed_command_input_select_tb;
    logic                clock_in = 1'b0;
    logic                rst_b_in = 1'b0;
    logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0, prdata, rd;
    logic                pready, pslverr, er, irq, ccw, drive_on, alarm;
    logic                emg, alarm_set = 1'b0, en_req = 1'b0;
    logic                trq, fwd, rev;
    logic [3:0]          mode_nv = 4'h2;
    logic                clr_req = 1'b0, safe = 1'b0;
    logic [1:0]          sel_req = 2'b00, idx;
    logic [8:0]          din;
    logic signed [16:0]  cmd;
    int                  mismatches = 0, check_count = 0, cycles = 0;
    logic signed [16:0]  exp_cmd [4] = '{17'h004d2, 17'h07530,
                                         17'h003e8, 17'h18ad0};

    always #12.5 clock_in = ~clock_in;

    scc_ctrl_model i_ctrl (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .enable_req_in(en_req), .alarm_clr_req_in(clr_req),
        .sel_req_in(sel_req), .safe_in(safe), .din_out(din));

    scc_speed_select i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .din_in(din),
        .analog_speed_in(17'h004d2), .mode_nv_in(mode_nv),
        .alarm_set_in(alarm_set), .speed_cmd_out(cmd),
        .speed_index_out(idx), .drive_on_out(drive_on), .ccw_out(ccw),
        .torque_limit_out(trq), .alarm_latched_out(alarm),
        .emergency_out(emg), .fwd_limit_out(fwd), .rev_limit_out(rev),
        .irq_out(irq));

    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; a clock edge always separates two transfers
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        do @(posedge clock_in); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Request to command takes five edges, alarm clear six; margin
    task settle();
        repeat (8) @(posedge clock_in);
    endtask : settle

    task report_and_stop();
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // Cut a hang short
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        repeat (8) @(posedge clock_in);
        rst_b_in <= 1'b1;
        settle();
        check(32'(emg), 32'h1);
        check(32'(drive_on), 32'h0);
        check(32'(fwd), 32'h1);
        check(32'(rev), 32'h1);
        check(32'(trq), 32'h0);
        apb(1'b0, 8'h34, 32'h0);
        check({28'h0, rd[11:8]}, 32'h2);
        apb(1'b1, 8'h04, 32'h00007530);
        apb(1'b1, 8'h08, 32'h000003e8);
        apb(1'b1, 8'h0c, 32'hffff8ad0);
        apb(1'b1, 8'h04, 32'h0000c351);            // Beyond the limit
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h00007530);
        apb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'hffff8ad0);
        apb(1'b0, 8'h80, 32'h0);
        check({31'h0, er}, 32'h1);
        // Range reject is the only unmasked cause
        apb(1'b1, 8'h3c, 32'h00000008);
        repeat (2) @(posedge clock_in);
        check(32'(irq), 32'h1);
        apb(1'b1, 8'h38, 32'h00000008);
        repeat (2) @(posedge clock_in);
        check(32'(irq), 32'h0);
        // Torque input made normally closed: an idle low pin acts
        apb(1'b1, 8'h14, 32'h00000009);
        settle();
        check(32'(trq), 32'h1);
        safe   <= 1'b1;
        en_req <= 1'b1;
        settle();
        check(32'(emg), 32'h0);
        check(32'(drive_on), 32'h1);
        check(32'(fwd), 32'h0);
        check(32'(rev), 32'h0);
        // Walk every source twice to show repeated switching
        for (int i = 0; i < 8; i++) begin
            sel_req <= i[1:0];
            settle();
            check(32'(idx), 32'(i[1:0]));
            check(32'(cmd), 32'(exp_cmd[i % 4]));
            check(32'(ccw), 32'(i % 4 == 3));
        end
        alarm_set <= 1'b1;
        @(posedge clock_in);
        alarm_set <= 1'b0;
        settle();
        check(32'(alarm), 32'h1);
        check(32'(cmd), 32'h0);
        clr_req <= 1'b1;
        settle();
        clr_req <= 1'b0;
        check(32'(alarm), 32'h0);
        check(32'(cmd), 32'(exp_cmd[3]));
        // Disable the low select input; a set pin must then do nothing
        apb(1'b1, 8'h18, 32'h00000000);
        sel_req <= 2'b01;
        settle();
        check(32'(idx), 32'h0);
        check(32'(cmd), 32'(exp_cmd[0]));
        // Enable as normally closed: a high pin now means off
        apb(1'b1, 8'h10, 32'h00000001);
        settle();
        check(32'(drive_on), 32'h0);
        apb(1'b1, 8'h10, 32'h00000101);
        en_req <= 1'b0;
        settle();
        check(32'(drive_on), 32'h0);
        check(32'(cmd), 32'h0);
        // Restart in another mode: enable must no longer energise
        mode_nv  <= 4'h1;
        en_req   <= 1'b1;
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        settle();
        check(32'(drive_on), 32'h0);
        apb(1'b0, 8'h34, 32'h0);
        check({28'h0, rd[11:8]}, 32'h1);
        report_and_stop();
    end
endmodule : speed_command_input_select_tb
